//--- design/lwbsc_core.sv
/*
 * Synchronous control of a flow-through burst SRAM with late write:
 * command decode, burst counter, stalls, output drivers and snooze.
 * Assumes all pins are synchronous to ref_clk and that the array port
 * returns mem_rdata combinationally from mem_raddr within the cycle.
 */
// Contract
// R1 - Sleep request high puts the device into snooze.
// R2 - Snooze lasts exactly while sleep request stays high.
// R3 - In snooze all inputs but sleep are ignored, data tristated.
// R4 - Controller finishes all accesses before raising sleep request.
// R5 - During wake-up the controller gives only deselect or read cycles.
// R6 - Inputs ignored two cycles after sleep rise, resampled two after fall; here ignored from the rise, resampled on the fourth edge after the fall.
// R7 - Two-bit burst counter: XOR step when interleaved, add modulo four linear.
// R8 - Burst address wraps to start every fourth cycle within its group.
// R9 - Every continue-burst cycle increments the burst counter first.
// R10 - Read or write of a burst fixed by the load cycle.
// R11 - Advance after a deselect load continues the deselect, tristated.
// R12 - Dummy read tristates; write with all lane enables high stores nothing.
// R13 - Write updates only lanes whose enables are low.
// R14 - Output drivers switch off during write cycles regardless of enable.
// R15 - Clock hold high freezes state; outputs stay driven reading, tristated writing.
// R16 - No array write on an edge where clock hold is high; here the write buffer still drains to the array on held edges.
// R17 - Controller inserts wait states by holding the clock hold high.
// R18 - Data outputs tristated from power-up until a valid read.
// R19 - Write data taken one edge after the write command.
// R20 - Advance high ignores address, chip selects and direction; counter steps.
// R21 - Load with first or third select high, or second low, deselects.
// R22 - Read data appear after the registering edge, before the next.
`timescale 1ns/1ns
`default_nettype none

`include "lwbsc_map.svh"

module lwbsc_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Command pins
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic advance_or_load,
    input wire logic read_not_write,
    input wire logic [`LWBSC_LANES-1:0] byte_write_n,
    input wire logic output_enable_n,
    input wire logic clock_hold_n,
    input wire logic burst_order_select_n,
    input wire logic sleep_request,
    input wire logic [`LWBSC_ADDR_W-1:0] addr,
    // Data pins, split three ways
    input wire logic [`LWBSC_DATA_W-1:0] dq_in,
    output logic [`LWBSC_DATA_W-1:0] dq_out,
    output logic dq_oe,
    // Array read port
    output logic [`LWBSC_ADDR_W-1:0] mem_raddr,
    input wire logic [`LWBSC_DATA_W-1:0] mem_rdata,
    // Array write port, drained from the write buffer
    output logic mem_we,
    input wire logic mem_wready,
    output logic [`LWBSC_ADDR_W-1:0] mem_waddr,
    output logic [`LWBSC_LANES-1:0] mem_wlane_en,
    output logic [`LWBSC_DATA_W-1:0] mem_wdata,
    // Status
    output logic snoozing,
    output logic wbuf_full
);
    // ----------------------------------------------------------------
    // Burst address step
    // ----------------------------------------------------------------
    // R7 xor or add
    function automatic logic [`LWBSC_BURST_W-1:0] burst_step(
        input logic [`LWBSC_BURST_W-1:0] start,
        input logic [`LWBSC_BURST_W-1:0] count,
        input logic interleaved
    );
        burst_step = interleaved ? (start ^ count) : (start + count);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    lwbsc_pkg::lwbsc_op_type op;
    lwbsc_pkg::lwbsc_op_type next_op;
    logic [`LWBSC_ADDR_W-1:0] base;
    logic [`LWBSC_ADDR_W-1:0] next_base;
    logic [`LWBSC_BURST_W-1:0] count;
    logic [`LWBSC_BURST_W-1:0] next_count;
    logic pend_wr;
    logic next_pend_wr;
    logic [`LWBSC_ADDR_W-1:0] pend_addr;
    logic [`LWBSC_ADDR_W-1:0] next_pend_addr;
    logic [`LWBSC_LANES-1:0] pend_lane;
    logic [`LWBSC_LANES-1:0] next_pend_lane;
    logic sleep_q;
    logic next_sleep_q;
    logic [`LWBSC_WAKE_CNT_W-1:0] wake_cnt;
    logic [`LWBSC_WAKE_CNT_W-1:0] next_wake_cnt;
    logic [`LWBSC_DATA_W-1:0] next_dq_out;
    logic next_dq_oe;
    logic next_wbuf_full;

    // Write buffer links
    lwbsc_pkg::lwbsc_wr_entry_type push_entry;
    lwbsc_pkg::lwbsc_wr_entry_type pop_entry;
    logic push_valid;
    logic push_ready;

    // Cycle qualifiers
    logic live;
    logic step;
    logic deselect_load;
    logic [`LWBSC_ADDR_W-1:0] cur_addr;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_op = op;
        next_base = base;
        next_count = count;
        next_pend_wr = pend_wr;
        next_pend_addr = pend_addr;
        next_pend_lane = pend_lane;
        next_dq_out = dq_out;
        next_dq_oe = dq_oe;
        push_valid = 1'b0;
        push_entry = '0;

        // R1 snooze entry
        next_sleep_q = sleep_request;
        // R6 wake delay
        if (sleep_q) begin
            next_wake_cnt = `LWBSC_WAKE_CNT_W'(`LWBSC_WAKE_INPUT_DELAY_CYC);
        end else if (wake_cnt != '0) begin
            next_wake_cnt = wake_cnt - 1'b1;
        end else begin
            next_wake_cnt = wake_cnt;
        end

        // R3 inputs ignored in snooze and while waking
        live = !sleep_q && !sleep_request && (wake_cnt == '0);
        // Full buffer with a write pending stalls like a hold, so no data is lost
        // R15 hold freezes op, burst count, pending write and outputs
        step = live && !clock_hold_n && !(pend_wr && !push_ready);
        // R21 deselect decode
        deselect_load = chip_sel_first_n || !chip_sel_second || chip_sel_third_n;
        next_wbuf_full = !push_ready;

        if (step) begin
            // R19 late write data
            if (pend_wr) begin
                push_valid = 1'b1;
                push_entry.addr = pend_addr;
                push_entry.lane_en = pend_lane;
                push_entry.data = dq_in;
            end
            next_pend_wr = 1'b0;
            if (!advance_or_load) begin
                next_base = addr;
                next_count = '0;
                if (deselect_load) begin
                    next_op = lwbsc_pkg::OP_DESELECT;
                end else begin
                    // R10 direction fixed at load
                    next_op = read_not_write ? lwbsc_pkg::OP_READ : lwbsc_pkg::OP_WRITE;
                end
            end else if (op != lwbsc_pkg::OP_DESELECT) begin
                // R20 pins ignored, counter steps
                // R9 step before access
                // R8 wraps modulo four
                next_count = count + 1'b1;
            end
            // R11 continued deselect keeps op
        end

        cur_addr = {next_base[`LWBSC_ADDR_W-1:`LWBSC_BURST_W],
                    burst_step(next_base[`LWBSC_BURST_W-1:0], next_count, burst_order_select_n)};

        if (step) begin
            case (next_op)
                lwbsc_pkg::OP_READ: begin
                    // R22 flow-through read
                    next_dq_out = mem_rdata;
                    // R12 dummy read tristates
                    next_dq_oe = !output_enable_n;
                end
                lwbsc_pkg::OP_WRITE: begin
                    // R14 drivers off in write
                    next_dq_oe = 1'b0;
                    // R13 lanes with low enables
                    // R12 all high aborts
                    if (byte_write_n != '1) begin
                        next_pend_wr = 1'b1;
                        next_pend_addr = cur_addr;
                        next_pend_lane = ~byte_write_n;
                    end
                end
                default: begin
                    next_dq_oe = 1'b0;
                end
            endcase
        end
        // R3 snooze tristates
        // R2 released with the request
        if (sleep_request || sleep_q) begin
            next_dq_oe = 1'b0;
        end
    end

    // Read address is the decoded address of the cycle being registered
    always_comb begin
        mem_raddr = cur_addr;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            op <= lwbsc_pkg::OP_DESELECT;
            base <= '0;
            count <= '0;
            pend_wr <= 1'b0;
            pend_addr <= '0;
            pend_lane <= '0;
            sleep_q <= 1'b0;
            wake_cnt <= '0;
            dq_out <= '0;
            // R18 tristated at power-up
            dq_oe <= 1'b0;
            wbuf_full <= 1'b0;
        end else begin
            op <= next_op;
            base <= next_base;
            count <= next_count;
            pend_wr <= next_pend_wr;
            pend_addr <= next_pend_addr;
            pend_lane <= next_pend_lane;
            sleep_q <= next_sleep_q;
            wake_cnt <= next_wake_cnt;
            dq_out <= next_dq_out;
            dq_oe <= next_dq_oe;
            wbuf_full <= next_wbuf_full;
        end
    end

    always_comb begin
        snoozing = sleep_q;
    end

    // ----------------------------------------------------------------
    // Write buffer
    // ----------------------------------------------------------------
    // R16 only stepping edges push, but the buffer still drains to the array on held edges
    lwbsc_fifo #(
        .WIDTH($bits(lwbsc_pkg::lwbsc_wr_entry_type)),
        .DEPTH(`LWBSC_WBUF_DEPTH)
    ) u_wbuf (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_entry),
        .out_valid(mem_we),
        .out_ready(mem_wready),
        .out_data(pop_entry)
    );

    always_comb begin
        mem_waddr = pop_entry.addr;
        mem_wlane_en = pop_entry.lane_en;
        mem_wdata = pop_entry.data;
    end

endmodule

`default_nettype wire

//--- pkg/lwbsc_map.svh
/*
 * Constants of the late-write burst SRAM control block: widths,
 * burst step, snooze delays and buffer depth.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef LWBSC_MAP_SVH
`define LWBSC_MAP_SVH

// ----------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------
`define LWBSC_ADDR_W 19
`define LWBSC_DATA_W 36
`define LWBSC_LANES 4
`define LWBSC_LANE_W 9
`define LWBSC_BURST_W 2

// ----------------------------------------------------------------
// Snooze timing, figures in clock cycles
// ----------------------------------------------------------------
`define LWBSC_SLEEP_INPUT_DELAY 2
`define LWBSC_WAKE_INPUT_DELAY 2
`define LWBSC_WAKE_INPUT_DELAY_CYC (`LWBSC_WAKE_INPUT_DELAY * 1)
`define LWBSC_WAKE_CNT_W 2

// ----------------------------------------------------------------
// Write buffer
// ----------------------------------------------------------------
`define LWBSC_WBUF_DEPTH 16

`endif

//--- pkg/lwbsc_pkg.sv
/*
 * Types shared by the SRAM control core and its write buffer.
 * Assumes lwbsc_map.svh is on the include path.
 */
`include "lwbsc_map.svh"

package lwbsc_pkg;

    // ----------------------------------------------------------------
    // Registered cycle kind
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_DESELECT,
        OP_READ,
        OP_WRITE
    } lwbsc_op_type;

    // ----------------------------------------------------------------
    // One buffered array write
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`LWBSC_ADDR_W-1:0] addr;
        logic [`LWBSC_LANES-1:0] lane_en;
        logic [`LWBSC_DATA_W-1:0] data;
    } lwbsc_wr_entry_type;

endpackage

//--- design/lwbsc_fifo.sv
/*
 * Write buffer: a first-in first-out queue with a registered output.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none

module lwbsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic [AW:0] fill;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // Pointer arithmetic
    // ----------------------------------------------------------------
    always_comb begin
        fill = wr_ptr - rd_ptr;
        in_ready = (fill != (AW+1)'(DEPTH));
        push = in_valid && in_ready;
        pop = (fill != '0) && (!out_valid || out_ready);
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_out_valid = pop ? 1'b1 : (out_valid && !out_ready);
        next_out_data = pop ? store[rd_ptr[AW-1:0]] : out_data;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end

    // Storage has no reset so it can map onto plain memory
    always_ff @(posedge ref_clk) begin
        if (push) begin
            store[wr_ptr[AW-1:0]] <= in_data;
        end
    end

endmodule

`default_nettype wire

//--- dv/lwbsc_checker.sv
/*
 * Port-level checker for the SRAM control core.
 * Assumes it is bound to lwbsc_core and sees only that module's ports.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lwbsc_map.svh"

module lwbsc_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Command pins
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic advance_or_load,
    input wire logic read_not_write,
    input wire logic output_enable_n,
    input wire logic clock_hold_n,
    input wire logic sleep_request,
    // Outputs and array side
    input wire logic [`LWBSC_DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic [`LWBSC_DATA_W-1:0] mem_rdata,
    input wire logic mem_we,
    input wire logic [`LWBSC_LANES-1:0] mem_wlane_en,
    input wire logic snoozing,
    input wire logic wbuf_full
);
    logic [1:0] wake;
    logic live;
    logic sel;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // Edges that really take a command; a full buffer is treated as a stall
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) wake <= 2'h0;
        else if (snoozing) wake <= 2'h2;
        else if (wake != 2'h0) wake <= wake - 2'h1;
    end
    assign live = !clock_hold_n && !sleep_request && !snoozing && wake == 2'h0 && !wbuf_full;
    assign sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;

    a_snooze_follow: assert property (snoozing == $past(sleep_request))
        else $error("snoozing does not follow sleep request");
    a_snooze_tristate: assert property (snoozing |-> !dq_oe)
        else $error("data driven in snooze");
    a_wake_wait: assert property ($fell(snoozing) |-> (!dq_oe) [*2])
        else $error("inputs taken too early after snooze");
    a_hold_freeze: assert property (clock_hold_n && !sleep_request && !snoozing
        |=> $stable(dq_out) && $stable(dq_oe)) else $error("outputs moved during hold");
    a_read_flow: assert property (live && !advance_or_load && sel && read_not_write
        && !output_enable_n |=> dq_oe && dq_out == $past(mem_rdata))
        else $error("read data not presented");
    a_dummy_read: assert property (live && !advance_or_load && sel && read_not_write
        && output_enable_n |=> !dq_oe) else $error("dummy read drives data");
    a_write_off: assert property (live && !advance_or_load && sel && !read_not_write
        |=> !dq_oe) else $error("write cycle drives data");
    a_deselect_off: assert property (live && !advance_or_load && !sel |=> !dq_oe)
        else $error("deselect drives data");
    a_lane_some: assert property (mem_we |-> mem_wlane_en != '0)
        else $error("array write with no lane");

    cover property (live && !advance_or_load && sel && !read_not_write);
    cover property (wbuf_full);
    cover property ($fell(snoozing));
endmodule

bind lwbsc_core lwbsc_checker chk_u (.ref_clk, .arst_n, .chip_sel_first_n, .chip_sel_second,
    .chip_sel_third_n, .advance_or_load, .read_not_write, .output_enable_n, .clock_hold_n,
    .sleep_request, .dq_out, .dq_oe, .mem_rdata, .mem_we, .mem_wlane_en, .snoozing, .wbuf_full);
`default_nettype wire

//--- dv/lwbsc_mem_model.sv
/*
 * Behavioural array behind the core: combinational read, lane-masked write.
 * Assumes unwritten words read back as a pattern made from their address.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lwbsc_map.svh"

module lwbsc_mem_model (
    // Clock and stall control
    input wire logic ref_clk,
    input wire logic stall,
    // Array ports
    input wire logic [`LWBSC_ADDR_W-1:0] mem_raddr,
    output logic [`LWBSC_DATA_W-1:0] mem_rdata,
    input wire logic mem_we,
    output logic mem_wready,
    input wire logic [`LWBSC_ADDR_W-1:0] mem_waddr,
    input wire logic [`LWBSC_LANES-1:0] mem_wlane_en,
    input wire logic [`LWBSC_DATA_W-1:0] mem_wdata
);
    logic [`LWBSC_DATA_W-1:0] mem [logic [`LWBSC_ADDR_W-1:0]];
    logic [`LWBSC_DATA_W-1:0] word;
    function automatic logic [`LWBSC_DATA_W-1:0] rd(input logic [`LWBSC_ADDR_W-1:0] a);
        return mem.exists(a) ? mem[a] : {~a[16:0], a};
    endfunction
    // Stall lets the bench hold the buffer full
    assign mem_wready = !stall;
    always @(mem_raddr or mem_we) mem_rdata = rd(mem_raddr);
    always @(posedge ref_clk) begin
        if (mem_we && mem_wready) begin
            word = rd(mem_waddr);
            for (int k = 0; k < `LWBSC_LANES; k++) begin
                if (mem_wlane_en[k]) word[k*`LWBSC_LANE_W +: `LWBSC_LANE_W] =
                    mem_wdata[k*`LWBSC_LANE_W +: `LWBSC_LANE_W];
            end
            mem[mem_waddr] = word;
        end
    end
endmodule
`default_nettype wire

//--- dv/test_late_write_burst_sram_control.sv
/*
 * Self-checking bench of the SRAM control core with its array model.
 * Assumes the checker is bound to the core from its own file.
 */
`timescale 1ns/1ns
`default_nettype none

module test_late_write_burst_sram_control;
    logic ref_clk, arst_n, chip_sel_first_n, chip_sel_second, chip_sel_third_n;
    logic advance_or_load, read_not_write, output_enable_n, clock_hold_n;
    logic burst_order_select_n, sleep_request, dq_oe, mem_we, mem_wready, snoozing;
    logic wbuf_full, stall;
    logic [3:0] byte_write_n, mem_wlane_en;
    logic [18:0] addr, mem_raddr, mem_waddr;
    logic [35:0] dq_in, dq_out, mem_rdata, mem_wdata, m;
    int fails, cmp_count, i, k, n;
    // Rows: order select, start address, the two low address bits of each of the four beats in burst order
    logic [27:0] rows [6] = '{28'h9a2c14e, 28'h05552b1, 28'h00fffc6, 28'hffff01b,
                              28'hb333ab1, 28'ha468be4};

    lwbsc_core dut_u (.ref_clk, .arst_n, .chip_sel_first_n, .chip_sel_second,
        .chip_sel_third_n, .advance_or_load, .read_not_write, .byte_write_n,
        .output_enable_n, .clock_hold_n, .burst_order_select_n, .sleep_request, .addr,
        .dq_in, .dq_out, .dq_oe, .mem_raddr, .mem_rdata, .mem_we, .mem_wready, .mem_waddr,
        .mem_wlane_en, .mem_wdata, .snoozing, .wbuf_full);
    lwbsc_mem_model mem_u (.ref_clk, .stall, .mem_raddr, .mem_rdata, .mem_we, .mem_wready,
        .mem_waddr, .mem_wlane_en, .mem_wdata);

    function automatic logic [35:0] pat(input logic [18:0] a);
        return {~a[16:0], a};
    endfunction
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({35'h0, got}, {35'h0, exp});
    endtask
    // One command per cycle: s selects none, or which chip select deselects
    task automatic cmd(input logic adv, input logic rw, input logic oen, input logic [1:0] s,
                       input logic [18:0] a);
        chip_sel_first_n = (s == 2'h1);
        chip_sel_second = (s != 2'h2);
        chip_sel_third_n = (s == 2'h3);
        advance_or_load = adv;
        read_not_write = rw;
        output_enable_n = oen;
        addr = a;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic final_report();
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Whole run is under two thousand cycles
    initial begin
        #100000;
        fails++;
        final_report();
    end

    initial begin
        {arst_n, advance_or_load, output_enable_n, sleep_request, stall} = 5'h0;
        {chip_sel_first_n, chip_sel_second, chip_sel_third_n, read_not_write} = 4'hf;
        {clock_hold_n, burst_order_select_n} = 2'h1;
        byte_write_n = 4'hf;
        addr = 19'h0;
        dq_in = 36'h123456789;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        chkb(dq_oe, 1'b0);
        chkb(snoozing, 1'b0);
        // Bursts from each row; advance cycles carry scrambled pins
        for (i = 0; i < 6; i++) begin
            burst_order_select_n = rows[i][27];
            cmd(1'b0, 1'b1, 1'b0, 2'h0, rows[i][26:8]);
            for (k = 0; k < 5; k++) begin
                chkb(dq_oe, 1'b1);
                chk(dq_out, pat({rows[i][26:10], rows[i][7-2*(k%4) -: 2]}));
                cmd(1'b1, 1'b0, 1'b0, 2'h2, 19'h0);
            end
        end
        // Hold in mid-burst ignores a load and keeps the data driven
        cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h1a2c1);
        clock_hold_n = 1'b1;
        for (k = 0; k < 3; k++) begin
            cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h00004);
            chk(dq_out, pat(19'h1a2c1));
            chkb(dq_oe, 1'b1);
        end
        clock_hold_n = 1'b0;
        cmd(1'b1, 1'b1, 1'b0, 2'h0, 19'h0);
        chk(dq_out, pat(19'h1a2c0));
        for (k = 1; k < 4; k++) begin
            cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h00100);
            chkb(dq_oe, 1'b1);
            cmd(1'b0, 1'b1, 1'b0, k[1:0], 19'h00104);
            chkb(dq_oe, 1'b0);
            cmd(1'b1, 1'b1, 1'b0, 2'h0, 19'h0);
            chkb(dq_oe, 1'b0);
        end
        cmd(1'b0, 1'b1, 1'b1, 2'h0, 19'h00108);
        chkb(dq_oe, 1'b0);
        // Long write burst against a stalled array fills the buffer
        stall = 1'b1;
        byte_write_n = 4'b1010;
        cmd(1'b0, 1'b0, 1'b0, 2'h0, 19'h0abc4);
        chkb(dq_oe, 1'b0);
        for (k = 0; k < 20; k++) cmd(1'b1, 1'b1, 1'b0, 2'h2, 19'h0);
        chkb(wbuf_full, 1'b1);
        cmd(1'b0, 1'b1, 1'b0, 2'h1, 19'h0);
        stall = 1'b0;
        for (n = 0; n < 100 && mem_we !== 1'b0; n++) @(negedge ref_clk);
        chkb(mem_we, 1'b0);
        m = 36'h007fc01ff;
        for (k = 0; k < 4; k++) begin
            cmd(1'b0, 1'b1, 1'b0, 2'h0, {17'h02af1, k[1:0]});
            chk(dq_out, (36'h123456789 & m) | (pat({17'h02af1, k[1:0]}) & ~m));
        end
        // Aborted write, then a write whose data edge follows a hold
        byte_write_n = 4'hf;
        cmd(1'b0, 1'b0, 1'b0, 2'h0, 19'h0abc8);
        byte_write_n = 4'h0;
        cmd(1'b0, 1'b0, 1'b0, 2'h0, 19'h0abcc);
        clock_hold_n = 1'b1;
        dq_in = 36'h0f0f0f0f0;
        cmd(1'b0, 1'b1, 1'b0, 2'h1, 19'h0);
        clock_hold_n = 1'b0;
        dq_in = 36'hfedcba987;
        repeat (4) cmd(1'b0, 1'b1, 1'b0, 2'h1, 19'h0);
        cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h0abc8);
        chk(dq_out, pat(19'h0abc8));
        cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h0abcc);
        chk(dq_out, 36'hfedcba987);
        // Snooze with reads pending on the pins; only reads while waking
        chkb(mem_we, 1'b0);
        sleep_request = 1'b1;
        cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h00204);
        chkb(snoozing, 1'b1);
        chkb(dq_oe, 1'b0);
        cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h00208);
        chkb(dq_oe, 1'b0);
        sleep_request = 1'b0;
        cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h0020c);
        chkb(snoozing, 1'b0);
        for (k = 0; k < 2; k++) begin
            cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h0020c);
            chkb(dq_oe, 1'b0);
        end
        cmd(1'b0, 1'b1, 1'b0, 2'h0, 19'h00210);
        chk(dq_out, pat(19'h00210));
        final_report();
    end
endmodule
`default_nettype wire
